// ==== sim/add_bit_exec_tb.sv ====
// self-checking bench for the add and bit operation execute block
`timescale 1ns/1ps
module add_bit_exec_tb;
  import exec_pkg::*;
  logic               clk, rst_n, instr_valid, file_we_q, skip_q, nop_exec_q;
  logic               carry_q, digit_carry_flag_q, zero_q;
  logic               r_c, r_dc, r_z, r_we, r_skip, r_nop, pend;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0]  file_rdata, file_wdata_q, acc_q, r_acc, r_wd, m;
  logic [ADDR_W-1:0]  file_addr_q;
  logic [DATA_W-1:0]  ref_mem [128];
  int                 err_total, comparisons;

  add_bit_exec add_bit_exec_i (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .file_we_q(file_we_q),
    .file_addr_q(file_addr_q), .file_wdata_q(file_wdata_q), .acc_q(acc_q),
    .carry_q(carry_q), .digit_carry_flag_q(digit_carry_flag_q), .zero_q(zero_q),
    .skip_q(skip_q), .nop_exec_q(nop_exec_q));
  file_space_model file_space_model_i (.clk(clk), .rd_addr(instr[6:0]), .we(file_we_q),
    .wr_addr(file_addr_q), .wdata(file_wdata_q), .rdata(file_rdata));

  // 100 ns core clock
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // addresses wrap 7c..01 so both ends and write-after-write hazards show up
  function automatic logic [INSTR_W-1:0] word(input int k);
    logic [6:0] a;
    logic [2:0] b;
    a = 7'($urandom % 6) + 7'h7c;
    b = 3'($urandom);
    case (k)
      0, 1: word = {OPC_ADD_ACC, b[0], a};
      2: word = {OPC_BIT_CLR, b, a};
      3: word = {OPC_BIT_SET, b, a};
      4: word = {OPC_TST_CLR, b, a};
      default: word = {4'h7, b, a}; // not ours: no effect
    endcase
  endfunction

  // one slot: drive on the falling edge, mirror at the rising one, then compare
  task automatic step(input logic v, input logic [INSTR_W-1:0] w);
    logic [8:0] s;
    @(negedge clk);
    instr_valid = v;
    instr = w;
    @(posedge clk);
    m = ref_mem[w[6:0]];
    s = r_acc + m;
    r_we = 1'h0;
    r_nop = v && pend;
    pend = pend && !v;
    if (v && !r_nop && w[13:8] == OPC_ADD_ACC)
    begin
      r_c = s[8];
      r_dc = 5'(r_acc[3:0]) + 5'(m[3:0]) > 5'h0f;
      r_z = s[7:0] == 8'h00;
      r_we = w[7];
      r_wd = w[7] ? s[7:0] : r_wd;
      r_acc = w[7] ? r_acc : s[7:0];
    end
    if (v && !r_nop && (w[13:10] == OPC_BIT_CLR || w[13:10] == OPC_BIT_SET))
    begin
      r_we = 1'h1;
      r_wd = m;
      r_wd[w[9:7]] = w[10];
    end
    r_skip = v && !r_nop && w[13:10] == OPC_TST_CLR && !m[w[9:7]];
    pend = pend || r_skip;
    if (r_we) ref_mem[w[6:0]] = r_wd;
    #1;
    chk("acc", r_acc, acc_q);
    chk("flags", {5'h00, r_c, r_dc, r_z}, {5'h00, carry_q, digit_carry_flag_q, zero_q});
    chk("write strobe", 8'(r_we), 8'(file_we_q));
    chk("write data", r_wd, file_wdata_q);
    if (r_we) chk("write address", 8'(w[6:0]), 8'(file_addr_q));
    chk("skip", 8'(r_skip), 8'(skip_q));
    chk("no-op slot", 8'(r_nop), 8'(nop_exec_q));
  endtask

  // reset, then a random stream with gaps, back to back slots and skips
  initial
  begin
    rst_n = 1'h0;
    instr_valid = 1'h0;
    instr = '0;
    {r_acc, r_wd, r_c, r_dc, r_z, pend} = '0;
    err_total = 0;
    comparisons = 0;
    for (int i = 0; i < 128; i++) ref_mem[i] = 8'(i * 29);
    void'($urandom(85));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    step(1'h0, '0);
    $display("test reset values done");
    for (int n = 0; n < 400; n++) step($urandom % 4 != 0, word($urandom % 6));
    $display("test random stream done");
    // park the block in its flush state, then reset: the pending skip must be forgotten
    step(1'h1, {OPC_BIT_CLR, 3'h2, 7'h10});
    step(1'h1, {OPC_TST_CLR, 3'h2, 7'h10});
    @(negedge clk);
    rst_n = 1'h0;
    instr_valid = 1'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    {r_acc, r_wd, r_c, r_dc, r_z, pend} = '0;
    step(1'h1, {OPC_BIT_SET, 3'h2, 7'h10});
    $display("test reset in flush done");
    for (int n = 0; n < 400; n++) step($urandom % 4 != 0, word($urandom % 6));
    $display("test second stream done");
    close_out();
  end

  // hang guard, far beyond the stream length
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule // add_bit_exec_tb

// ==== sim/file_space_model.sv ====
// file register array facing the block, with forwarding of its pending write
`timescale 1ns/1ps
module file_space_model
  import exec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] rd_addr,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [128];
  // known fill so the bench can mirror it
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 29);
  // a write lands at the edge that closes its cycle
  // plain always: the fill above also writes this array
  always @(posedge clk) if (we) mem[wr_addr] <= wdata;
  // forwarding is ours, the block reads only what we show
  assign rdata = (we && wr_addr == rd_addr) ? wdata : mem[rd_addr];
endmodule // file_space_model

// ==== verilog/add_bit_exec.sv ====
// decode and execute of the add, bit clear, bit set and test skip instructions
`timescale 1ns/1ps
module add_bit_exec
  import exec_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic [DATA_W-1:0]  file_rdata,
  output logic                    file_we_q,
  output logic      [ADDR_W-1:0]  file_addr_q,
  output logic      [DATA_W-1:0]  file_wdata_q,
  output logic      [DATA_W-1:0]  acc_q,
  output logic                    carry_q,
  output logic                    digit_carry_flag_q,
  output logic                    zero_q,
  output logic                    skip_q,
  output logic                    nop_exec_q
);
  exec_state_t       state_q, state_d;
  logic              file_we_d;
  logic [ADDR_W-1:0] file_addr_d;
  logic [DATA_W-1:0] file_wdata_d;
  logic [DATA_W-1:0] acc_d;
  logic              carry_d;
  logic              dcf_d;
  logic              zero_d;
  logic              skip_d;
  logic              nop_d;

  logic              exec_go;
  logic              is_add;
  logic              is_clr;
  logic              is_set;
  logic              is_tst;
  logic [BSEL_W-1:0] bsel;
  logic [DATA_W-1:0] bmask;
  logic [DATA_W-1:0] add_sum;
  logic              add_c;
  logic              add_dc;
  logic              add_z;

  // field decode
  assign exec_go = instr_valid && (state_q == ST_EXEC);
  assign is_add  = (instr[INSTR_W-1 -: $bits(OPC_ADD_ACC)] == OPC_ADD_ACC);
  assign is_clr  = (instr[INSTR_W-1 -: $bits(OPC_BIT_CLR)] == OPC_BIT_CLR);
  assign is_set  = (instr[INSTR_W-1 -: $bits(OPC_BIT_SET)] == OPC_BIT_SET);
  assign is_tst  = (instr[INSTR_W-1 -: $bits(OPC_TST_CLR)] == OPC_TST_CLR);
  assign bsel    = instr[BSEL_LSB +: BSEL_W];
  assign bmask   = DATA_W'(ONE_BIT << bsel);

  add_flag_unit #(
    .WIDTH (DATA_W)
  ) u_add (
    .a                (acc_q),
    .b                (file_rdata),
    .sum              (add_sum),
    .carry            (add_c),
    .digit_carry_flag (add_dc),
    .zero             (add_z)
  );

  // next state; unknown opcodes pass through with no effect
  always_comb
  begin
    state_d      = state_q;
    file_we_d    = 1'b0;
    file_addr_d  = file_addr_q;
    file_wdata_d = file_wdata_q;
    acc_d        = acc_q;
    carry_d      = carry_q;
    dcf_d        = digit_carry_flag_q;
    zero_d       = zero_q;
    skip_d       = 1'b0;
    nop_d        = 1'b0;
    case (state_q)
      ST_EXEC:
      begin
        if (instr_valid)
        begin
          file_addr_d = instr[ADDR_LSB +: ADDR_W];
          if (is_add)
          begin
            carry_d = add_c;
            dcf_d   = add_dc;
            zero_d  = add_z;
            if (instr[DEST_POS])
            begin
              file_we_d    = 1'b1;
              file_wdata_d = add_sum;
            end
            else
            begin
              acc_d = add_sum;
            end
          end
          else if (is_clr)
          begin
            file_we_d    = 1'b1;
            file_wdata_d = file_rdata & ~bmask;
          end
          else if (is_set)
          begin
            file_we_d    = 1'b1;
            file_wdata_d = file_rdata | bmask;
          end
          else if (is_tst && ((file_rdata & bmask) == ZERO_BYTE))
          begin
            skip_d  = 1'b1;
            state_d = ST_FLUSH;
          end
        end
      end
      ST_FLUSH:
      begin
        // the prefetched word is dropped whatever it is; wait until it shows
        if (instr_valid)
        begin
          nop_d   = 1'b1;
          state_d = ST_EXEC;
        end
      end
      default:
      begin
        state_d = ST_EXEC;
      end
    endcase
  end

  // registers, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q            <= ST_EXEC;
      file_we_q          <= 1'b0;
      file_addr_q        <= ADDR_RST;
      file_wdata_q       <= ACC_RST;
      acc_q              <= ACC_RST;
      carry_q            <= 1'b0;
      digit_carry_flag_q <= 1'b0;
      zero_q             <= 1'b0;
      skip_q             <= 1'b0;
      nop_exec_q         <= 1'b0;
    end
    else
    begin
      state_q            <= state_d;
      file_we_q          <= file_we_d;
      file_addr_q        <= file_addr_d;
      file_wdata_q       <= file_wdata_d;
      acc_q              <= acc_d;
      carry_q            <= carry_d;
      digit_carry_flag_q <= dcf_d;
      zero_q             <= zero_d;
      skip_q             <= skip_d;
      nop_exec_q         <= nop_d;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_add_flags: assert property (exec_go && is_add |=>
    (zero_q == (DATA_W'($past(acc_q) + $past(file_rdata)) == ZERO_BYTE)) &&
    (carry_q == (({1'b0, $past(acc_q)} + {1'b0, $past(file_rdata)}) > 9'h0ff)))
    else $error("add flags wrong");
  a_add_dest_w: assert property (exec_go && is_add && !instr[DEST_POS] |=>
    !file_we_q && acc_q == DATA_W'($past(acc_q) + $past(file_rdata)))
    else $error("add to accumulator wrong");
  a_add_dest_f: assert property (exec_go && is_add && instr[DEST_POS] |=>
    file_we_q && $stable(acc_q) && file_wdata_q == DATA_W'($past(acc_q) + $past(file_rdata)))
    else $error("add to file wrong");
  a_clear_bit: assert property (exec_go && is_clr |=>
    file_we_q && file_wdata_q[$past(bsel)] == 1'b0 && $stable(zero_q) && $stable(carry_q) &&
    (file_wdata_q | $past(bmask)) == ($past(file_rdata) | $past(bmask)))
    else $error("bit clear wrong");
  a_set_bit: assert property (exec_go && is_set |=>
    file_we_q && file_wdata_q[$past(bsel)] == 1'b1 && $stable(zero_q) &&
    (file_wdata_q & ~$past(bmask)) == ($past(file_rdata) & ~$past(bmask)))
    else $error("bit set wrong");
  a_test_skip: assert property (exec_go && is_tst |=>
    skip_q == !$past(file_rdata[bsel]) && !file_we_q && $stable(zero_q))
    else $error("test skip decision wrong");
  a_flush_nop: assert property (skip_q ##0 instr_valid |=>
    nop_exec_q && !file_we_q && $stable(acc_q) && $stable(carry_q) ##1 !nop_exec_q)
    else $error("skipped slot not a no-operation");
  a_addr_field: assert property (exec_go |=>
    file_addr_q == $past(instr[ADDR_LSB +: ADDR_W]))
    else $error("file address field wrong");

  // digit carry is the carry out of the low nibble only
  a_add_digit: assert property (exec_go && is_add |=>
    digit_carry_flag_q ==
    (({1'b0, $past(acc_q[NIB_W-1:0])} + {1'b0, $past(file_rdata[NIB_W-1:0])}) > 5'h0f))
    else $error("add digit carry wrong");
  // bit operations, tests and unknown words leave the flags and accumulator alone
  a_flags_kept: assert property (exec_go && !is_add |=>
    $stable(carry_q) && $stable(digit_carry_flag_q) && $stable(zero_q) &&
    $stable(acc_q))
    else $error("flags moved without an add");
  // a write strobe only ever follows an accepted add to file, bit clear or bit set
  a_write_source: assert property (file_we_q |->
    $past(exec_go && ((is_add && instr[DEST_POS]) || is_clr || is_set)))
    else $error("write strobe without a writing instruction");
  a_skip_source: assert property (skip_q |->
    $past(exec_go && is_tst) && state_q == ST_FLUSH)
    else $error("skip without a test of a clear bit");

  // a gap while flushing only waits; the next valid word becomes the no-operation
  a_flush_hold: assert property (state_q == ST_FLUSH && !instr_valid |=>
    state_q == ST_FLUSH && !nop_exec_q && !file_we_q)
    else $error("flush left during a gap");
  a_flush_wait: assert property (state_q == ST_FLUSH && instr_valid |=>
    nop_exec_q && state_q == ST_EXEC && !file_we_q && $stable(acc_q) && $stable(zero_q))
    else $error("flushed slot had an effect");

  c_add_to_file: cover property (exec_go && is_add && instr[DEST_POS]);
  c_skip_taken:  cover property (skip_q ##1 nop_exec_q);
  c_bit_set:     cover property (exec_go && is_set);
  c_add_carry:   cover property (exec_go && is_add && add_c && add_dc);
  c_flush_gap:   cover property (state_q == ST_FLUSH && !instr_valid);
endmodule // add_bit_exec

// ==== verilog/add_flag_unit.sv ====
// eight bit adder with carry, digit carry and zero outputs
`timescale 1ns/1ps
module add_flag_unit
  import exec_pkg::*;
#(
  parameter int WIDTH = DATA_W
)(
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  output logic      [WIDTH-1:0] sum,
  output logic                  carry,
  output logic                  digit_carry_flag,
  output logic                  zero
);
  logic [WIDTH:0] full;
  logic [NIB_W:0] low;

  // digit carry comes from a separate low nibble add, cheaper than tapping the chain
  always_comb
  begin
    full             = {1'b0, a} + {1'b0, b};
    low              = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]};
    sum              = full[WIDTH-1:0];
    carry            = full[WIDTH];
    digit_carry_flag = low[NIB_W];
    zero             = (full[WIDTH-1:0] == '0);
  end
endmodule // add_flag_unit

// ==== verilog/exec_pkg.sv ====
// constants and types for the add and bit operation execute block
// Contract
// - the add opcode sums the accumulator and the addressed file register and updates carry, digit carry and zero.
// - a destination bit of 0 puts the add result in the accumulator, a 1 puts it back in the file register.
// - the bit clear opcode forces the selected bit to zero, keeps the other bits and flags, in one cycle.
// - the bit set opcode forces the selected bit to one, keeps the other bits and flags, in one cycle.
// - the test opcode skips the next instruction when the selected bit is zero, flags unchanged.
// - a taken skip discards the fetched instruction and runs a no-operation, so the test takes two cycles.
package exec_pkg;
  localparam int INSTR_W     = 14;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int ADDR_LSB    = 0;
  localparam int BSEL_LSB    = 7;
  localparam int BSEL_W      = 3;
  localparam int DEST_POS    = 7;
  localparam int NIB_W       = 4;
  // opcode groups
  localparam logic [5:0] OPC_ADD_ACC  = 6'h07;   // bits 13:8
  localparam logic [3:0] OPC_BIT_CLR  = 4'h4;    // bits 13:10
  localparam logic [3:0] OPC_BIT_SET  = 4'h5;
  localparam logic [3:0] OPC_TST_CLR  = 4'h6;
  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BIT   = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 7'h00;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } exec_state_t;
endpackage
